// ---- rtl/status_one_pkg.sv ----
// constants, opcodes and helper functions for the status-one register logic
package status_one_pkg;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_ENABLE_VOL = 8'h50;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_REG_WRITE = 8'h01;
  localparam logic [7:0] CMD_ADDR_REG_WRITE = 8'h71;
  localparam logic [7:0] CMD_ADDR_REG_READ = 8'h65;
  localparam logic [7:0] CMD_STATUS_ONE_READ = 8'h05;
  localparam logic [7:0] CMD_STATUS_TWO_READ = 8'h07;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
  localparam logic [7:0] CMD_RESET_ARM = 8'h66;
  localparam logic [7:0] CMD_RESET_EXECUTE = 8'h99;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_QUAD_PROGRAM = 8'h32;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] CMD_CHIP_ERASE_ALT = 8'h60;
  // addressed register map for the two status-one copies
  localparam logic [23:0] ADDR_STATUS_DEFAULTS = 24'h000000;
  localparam logic [23:0] ADDR_STATUS_LIVE = 24'h800000;
  // field positions inside status_one
  localparam int LOCK_POS = 7;
  localparam int BOTTOM_POS = 6;
  localparam int RANGE_HI = 5;
  localparam int RANGE_LO = 2;
  localparam int LATCH_POS = 1;
  localparam int BUSY_POS = 0;
  // shipped value of the user part of the defaults copy (bits 7..2)
  localparam logic [5:0] DEFAULTS_SHIPPED = 6'h00;
  // byte index at which each command acts
  localparam logic [2:0] IDX_CMD = 3'h0;
  localparam logic [2:0] IDX_REG_DATA = 3'h1;
  localparam logic [2:0] IDX_ADDR_DONE = 3'h3;
  localparam logic [2:0] IDX_ADDR_DATA = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_HOLD = 2'b11
  } op_state_t;

  function automatic logic [2:0] bin2gray(input logic [2:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [2:0] gray2bin(input logic [2:0] g);
    return {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
  endfunction

  function automatic logic is_array_op(input logic [7:0] c);
    return c == CMD_PAGE_PROGRAM || c == CMD_QUAD_PROGRAM || c == CMD_SECTOR_ERASE ||
           c == CMD_HALF_BLOCK_ERASE || c == CMD_BLOCK_ERASE || c == CMD_CHIP_ERASE ||
           c == CMD_CHIP_ERASE_ALT;
  endfunction
endpackage

// ---- rtl/status_one_protect_busy_logic.sv ----
// status-one register pair with latch, busy, error hold and write-protect locking
`timescale 1ns/10ps
module status_one_protect_busy_logic
  import status_one_pkg::*;
#(
  parameter logic LATCH_FACTORY = 1'b0,
  parameter logic BUSY_FACTORY = 1'b0
) (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  output logic miso,
  input wire logic wp_b,
  input wire logic quad_command_mode,
  input wire logic quad_io_mode,
  input wire logic op_done,
  input wire logic erase_fail,
  input wire logic program_fail,
  output logic op_start,
  output logic [7:0] op_code,
  output logic suspend_req,
  output logic soft_reset,
  output logic [7:0] status_one_live,
  output logic [7:0] status_one_defaults,
  output logic erase_fail_flag,
  output logic program_fail_flag
);

  // ---------------- link side, clocked by the serial clock ----------------
  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] bits;
    logic [2:0] nbytes;
    logic [2:0] count_gray;
    logic [7:0] byte_out;
    logic [7:0] out_shift;
    logic reading;
  } link_t;

  link_t link_reg, link_next;
  logic [7:0] shadow_word;
  logic [7:0] in_byte;

  // the bit counter must restart with every frame, and the serial clock is
  // stopped between frames, so chip select itself clears the link state
  // limitation: select must stay low about four core cycles after the last edge
  always_comb begin
    in_byte = {link_reg.shift[6:0], mosi};
    link_next = link_reg;
    link_next.shift = in_byte;
    link_next.bits = link_reg.bits + 3'h1;
    link_next.out_shift = {link_reg.out_shift[6:0], 1'b0};
    if (link_reg.bits == 3'h7) begin
      link_next.byte_out = in_byte;
      if (link_reg.nbytes != 3'h7) begin
        link_next.nbytes = link_reg.nbytes + 3'h1;
        link_next.count_gray = bin2gray(link_reg.nbytes + 3'h1);
      end
      if (link_reg.nbytes == 3'h0) begin
        link_next.reading = (in_byte == CMD_STATUS_ONE_READ);
      end
      if ((link_reg.nbytes == 3'h0 && in_byte == CMD_STATUS_ONE_READ) || link_reg.reading) begin
        link_next.out_shift = shadow_word;
      end
    end
  end

  always_ff @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  assign miso = link_reg.out_shift[7];

  // ---------------- core side ----------------
  typedef struct packed {
    logic wp_s1;
    logic wp_s2;
    logic cs_s1;
    logic cs_s2;
    logic [2:0] cnt_s1;
    logic [2:0] cnt_s2;
    logic [2:0] seen;
    op_state_t state;
    logic [5:0] nv_user;
    logic lock;
    logic bottom;
    logic [3:0] range;
    logic write_enable_latch;
    logic write_in_progress;
    logic vol_en;
    logic ef;
    logic pf;
    logic [7:0] cmd;
    logic cmd_ok;
    logic [23:0] addr;
    logic arm;
    logic [7:0] op_code;
    logic op_start;
    logic suspend_req;
    logic soft_reset;
    logic [7:0] shadow;
  } core_t;

  localparam core_t CORE_RESET = '{
    state: (BUSY_FACTORY ? ST_BUSY : ST_IDLE),
    nv_user: DEFAULTS_SHIPPED,
    lock: DEFAULTS_SHIPPED[LOCK_POS - RANGE_LO],
    bottom: DEFAULTS_SHIPPED[BOTTOM_POS - RANGE_LO],
    range: DEFAULTS_SHIPPED[RANGE_HI - RANGE_LO:0],
    write_enable_latch: LATCH_FACTORY,
    write_in_progress: BUSY_FACTORY,
    cs_s1: 1'b1,
    cs_s2: 1'b1,
    wp_s1: 1'b1,
    wp_s2: 1'b1,
    default: '0
  };

  core_t core_reg, core_next;
  logic [2:0] cnt_bin;
  logic ev;
  logic [2:0] idx;
  logic [7:0] ev_byte;
  logic hw_lock;
  logic fail_in;
  logic reg_ok;
  logic start_ok;

  assign shadow_word = core_reg.shadow;

  function automatic logic busy_allowed(input logic [7:0] c);
    return c == CMD_STATUS_ONE_READ || c == CMD_STATUS_TWO_READ || c == CMD_ADDR_REG_READ ||
           c == CMD_SUSPEND || c == CMD_CLEAR_STATUS || c == CMD_RESET_ARM || c == CMD_RESET_EXECUTE;
  endfunction

  always_comb begin
    core_next = core_reg;
    cnt_bin = gray2bin(core_reg.cnt_s2);
    ev = !core_reg.cs_s2 && cnt_bin != 3'h0 && cnt_bin != core_reg.seen;
    idx = cnt_bin - 3'h1;
    ev_byte = link_reg.byte_out;
    // quad modes reuse the protect pin as a data line
    hw_lock = core_reg.lock && !(core_reg.wp_s2 || quad_command_mode || quad_io_mode);
    fail_in = erase_fail || program_fail;
    reg_ok = core_reg.cmd_ok && core_reg.write_enable_latch && !core_reg.write_in_progress && !hw_lock;
    start_ok = core_reg.cmd_ok && core_reg.write_enable_latch && !core_reg.write_in_progress;

    core_next.wp_s1 = wp_b;
    core_next.wp_s2 = core_reg.wp_s1;
    core_next.cs_s1 = cs_b;
    core_next.cs_s2 = core_reg.cs_s1;
    core_next.cnt_s1 = link_reg.count_gray;
    core_next.cnt_s2 = core_reg.cnt_s1;
    core_next.op_start = 1'b0;
    core_next.suspend_req = 1'b0;
    core_next.soft_reset = 1'b0;
    if (core_reg.cs_s2) begin
      core_next.seen = 3'h0;
    end else if (ev) begin
      core_next.seen = cnt_bin;
    end

    if (ev && idx == IDX_CMD) begin
      core_next.cmd = ev_byte;
      core_next.cmd_ok = !core_reg.write_in_progress || busy_allowed(ev_byte);
      core_next.arm = 1'b0;
      if (!core_reg.write_in_progress || busy_allowed(ev_byte)) begin
        case (ev_byte)
          CMD_WRITE_ENABLE: begin
            core_next.write_enable_latch = 1'b1;
            core_next.vol_en = 1'b0;
          end
          CMD_WRITE_ENABLE_VOL: begin
            core_next.write_enable_latch = 1'b1;
            core_next.vol_en = 1'b1;
          end
          CMD_WRITE_DISABLE: begin
            core_next.write_enable_latch = 1'b0;
          end
          CMD_CLEAR_STATUS: begin
            core_next.write_enable_latch = 1'b0;
            core_next.ef = 1'b0;
            core_next.pf = 1'b0;
            if (core_reg.state == ST_HOLD) begin
              core_next.state = ST_IDLE;
              core_next.write_in_progress = 1'b0;
            end
          end
          CMD_RESET_ARM: begin
            core_next.arm = 1'b1;
          end
          CMD_RESET_EXECUTE: begin
            if (core_reg.arm) begin
              // live copy reloads from the defaults, factory bits included
              core_next.lock = core_reg.nv_user[LOCK_POS - RANGE_LO];
              core_next.bottom = core_reg.nv_user[BOTTOM_POS - RANGE_LO];
              core_next.range = core_reg.nv_user[RANGE_HI - RANGE_LO:0];
              core_next.write_enable_latch = LATCH_FACTORY;
              core_next.write_in_progress = BUSY_FACTORY;
              core_next.state = BUSY_FACTORY ? ST_BUSY : ST_IDLE;
              core_next.ef = 1'b0;
              core_next.pf = 1'b0;
              core_next.soft_reset = 1'b1;
            end
          end
          CMD_SUSPEND: begin
            if (core_reg.state == ST_BUSY && is_array_op(core_reg.op_code)) begin
              core_next.suspend_req = 1'b1;
            end
          end
          CMD_CHIP_ERASE, CMD_CHIP_ERASE_ALT: begin
            if (core_reg.write_enable_latch && !core_reg.write_in_progress) begin
              core_next.op_start = 1'b1;
              core_next.op_code = ev_byte;
              core_next.state = ST_BUSY;
              core_next.write_in_progress = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (ev && core_reg.cmd_ok) begin
      if (idx <= IDX_ADDR_DONE) begin
        core_next.addr = {core_reg.addr[15:0], ev_byte};
      end
      if (idx == IDX_ADDR_DONE && is_array_op(core_reg.cmd) && start_ok) begin
        core_next.op_start = 1'b1;
        core_next.op_code = core_reg.cmd;
        core_next.state = ST_BUSY;
        core_next.write_in_progress = 1'b1;
      end
      // only bits 7..2 take written data; a defaults write sets busy, a live write clears the latch
      if (reg_ok && ((idx == IDX_REG_DATA && core_reg.cmd == CMD_REG_WRITE && !core_reg.vol_en) ||
          (idx == IDX_ADDR_DATA && core_reg.cmd == CMD_ADDR_REG_WRITE &&
           core_reg.addr == ADDR_STATUS_DEFAULTS))) begin
        core_next.nv_user = ev_byte[7:2];
        core_next.lock = ev_byte[LOCK_POS];
        core_next.bottom = ev_byte[BOTTOM_POS];
        core_next.range = ev_byte[RANGE_HI:RANGE_LO];
        core_next.op_start = 1'b1;
        core_next.op_code = core_reg.cmd;
        core_next.state = ST_BUSY;
        core_next.write_in_progress = 1'b1;
      end
      if (reg_ok && ((idx == IDX_REG_DATA && core_reg.cmd == CMD_REG_WRITE && core_reg.vol_en) ||
          (idx == IDX_ADDR_DATA && core_reg.cmd == CMD_ADDR_REG_WRITE &&
           core_reg.addr == ADDR_STATUS_LIVE))) begin
        core_next.lock = ev_byte[LOCK_POS];
        core_next.bottom = ev_byte[BOTTOM_POS];
        core_next.range = ev_byte[RANGE_HI:RANGE_LO];
        core_next.write_enable_latch = 1'b0;
      end
    end

    // engine results; a fail in the same cycle as clear-status wins
    if (core_reg.state == ST_BUSY) begin
      if (erase_fail) begin
        core_next.ef = 1'b1;
      end
      if (program_fail) begin
        core_next.pf = 1'b1;
      end
      if (fail_in) begin
        core_next.state = ST_HOLD;
        core_next.write_in_progress = 1'b1;
      end else if (op_done) begin
        core_next.state = ST_IDLE;
        core_next.write_in_progress = 1'b0;
        core_next.write_enable_latch = 1'b0;
      end
    end

    // frozen during a frame so the link can read it without tearing
    if (core_reg.cs_s2) begin
      core_next.shadow = {core_next.lock, core_next.bottom, core_next.range, core_next.write_enable_latch, core_next.write_in_progress};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      core_reg <= CORE_RESET;
    end else if (clk_en) begin
      core_reg <= core_next;
    end
  end

  assign op_start = core_reg.op_start;
  assign op_code = core_reg.op_code;
  assign suspend_req = core_reg.suspend_req;
  assign soft_reset = core_reg.soft_reset;
  assign status_one_live = {core_reg.lock, core_reg.bottom, core_reg.range, core_reg.write_enable_latch, core_reg.write_in_progress};
  assign status_one_defaults = {core_reg.nv_user, LATCH_FACTORY, BUSY_FACTORY};
  assign erase_fail_flag = core_reg.ef;
  assign program_fail_flag = core_reg.pf;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  write_enable_cmd_sets_a: assert property (clk_en && ev && idx == IDX_CMD && ev_byte == CMD_WRITE_ENABLE && !core_reg.write_in_progress
    |=> core_reg.write_enable_latch) else $error("write enable did not set latch");
  write_disable_cmd_clears_a: assert property (clk_en && ev && idx == IDX_CMD && ev_byte == CMD_WRITE_DISABLE
    && !core_reg.write_in_progress && core_reg.state != ST_BUSY |=> !core_reg.write_enable_latch) else $error("write disable kept latch");
  start_needs_latch_a: assert property (core_reg.op_start |-> $past(core_reg.write_enable_latch) && $past(!core_reg.write_in_progress))
    else $error("operation started without latch");
  done_clears_a: assert property (clk_en && core_reg.state == ST_BUSY && op_done && !fail_in
    |=> !core_reg.write_enable_latch && !core_reg.write_in_progress && core_reg.state == ST_IDLE) else $error("completion left latch or busy");
  fail_hold_a: assert property (clk_en && core_reg.state == ST_BUSY && fail_in
    |=> core_reg.write_in_progress && core_reg.state == ST_HOLD) else $error("busy dropped after failure");
  clear_release_a: assert property (clk_en && core_reg.state == ST_HOLD && ev && idx == IDX_CMD
    && ev_byte == CMD_CLEAR_STATUS |=> !core_reg.write_in_progress && !core_reg.ef && !core_reg.pf && !core_reg.write_enable_latch)
    else $error("clear status did not release hold");
  lock_blocks_a: assert property (clk_en && hw_lock && !core_next.soft_reset
    |=> $stable(core_reg.nv_user)) else $error("locked defaults changed");
  suspend_gate_a: assert property (core_reg.suspend_req
    |-> $past(core_reg.state) == ST_BUSY && is_array_op(core_reg.op_code)) else $error("bad suspend");
  track_default_a: assert property ($changed(core_reg.nv_user)
    |-> {core_reg.lock, core_reg.bottom} == core_reg.nv_user[5:4]) else $error("live lock bits not tracking");
  wip_state_a: assert property (core_reg.write_in_progress == (core_reg.state != ST_IDLE))
    else $error("busy bit disagrees with state");
  busy_refuse_a: assert property (clk_en && ev && idx == IDX_CMD && core_reg.write_in_progress && !busy_allowed(ev_byte)
    |=> !core_reg.cmd_ok && !core_reg.op_start)
    else $error("command accepted while busy");
  fail_update_a: assert property (clk_en && core_reg.state == ST_BUSY
    |=> (core_reg.ef || !$past(erase_fail)) && (core_reg.pf || !$past(program_fail)))
    else $error("fail flag missed during busy period");
  reset_load_a: assert property ($rose(rst_b)
    |-> core_reg.write_enable_latch == LATCH_FACTORY && core_reg.write_in_progress == BUSY_FACTORY)
    else $error("reset did not load factory bits");
  locked_write_a: assert property (clk_en && ev && idx == IDX_REG_DATA && core_reg.cmd == CMD_REG_WRITE
    && hw_lock && !core_reg.write_in_progress |=> $stable(status_one_live[7:1]) && !core_reg.op_start)
    else $error("locked register write took effect");
  quad_unlock_a: assert property (clk_en && ev && idx == IDX_REG_DATA && core_reg.cmd == CMD_REG_WRITE
    && core_reg.vol_en && core_reg.cmd_ok && core_reg.write_enable_latch && !core_reg.write_in_progress && (quad_command_mode || quad_io_mode)
    |=> !core_reg.write_enable_latch) else $error("quad mode did not lift register lock");

  op_run_c: cover property (core_reg.op_start ##[1:50] core_reg.state == ST_IDLE);
  fail_clear_c: cover property (core_reg.state == ST_HOLD ##[1:200] core_reg.state == ST_IDLE);
  suspend_c: cover property (core_reg.suspend_req);
  locked_c: cover property (hw_lock && ev && core_reg.cmd == CMD_REG_WRITE);
  chip_erase_c: cover property (core_reg.op_start && core_reg.op_code == CMD_CHIP_ERASE);
endmodule

// ---- tb/spi_host_model.sv ----
// host-side serial controller model that frames flash commands on the link
`timescale 1ns/10ps
module spi_host_model
  import status_one_pkg::*;
(
  output logic sclk,
  output logic cs_b,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end

  // mode 0: data changes while the clock is low, the device takes it on the rising edge
  task automatic shift(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
  endtask

  // clock stands low outside frames; a released data line is inverted so a stale level never looks valid
  task automatic close_frame();
    // select stays low until the core has taken the last byte through its synchroniser
    #37.5 cs_b = 1'b1;
    mosi = ~mosi;
    // gap covers the core's byte sync and the minimum deselect time
    #100;
  endtask

  task automatic frame(input logic [7:0] bytes [$]);
    cs_b = 1'b0;
    #7.5;
    foreach (bytes[i]) shift(bytes[i]);
    close_frame();
  endtask

  task automatic read_status(output logic [7:0] v);
    cs_b = 1'b0;
    #7.5;
    shift(CMD_STATUS_ONE_READ);
    for (int i = 7; i >= 0; i--) begin
      mosi = ~mosi;
      #7.5 v[i] = miso;
      sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
    close_frame();
  endtask
endmodule

// ---- tb/status_one_protect_busy_logic_tb_top.sv ----
// self-checking bench for the status-one latch, busy and protect logic
`timescale 1ns/10ps
module status_one_protect_busy_logic_tb_top;
  import status_one_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  logic quad_command_mode = 1'b0;
  logic quad_io_mode = 1'b0;
  logic op_done = 1'b0;
  logic erase_fail = 1'b0;
  logic program_fail = 1'b0;
  logic sclk;
  logic cs_b;
  logic mosi;
  logic miso;
  logic op_start;
  logic suspend_req;
  logic soft_reset;
  logic erase_fail_flag;
  logic program_fail_flag;
  logic [7:0] op_code;
  logic [7:0] status_one_live;
  logic [7:0] status_one_defaults;
  logic [7:0] rd;
  int bad_count = 0;
  int checked = 0;
  int starts = 0;
  int suspends = 0;
  int resets = 0;

  always #5 clk = ~clk;

  // pulses last one cycle, so they are counted rather than sampled
  always @(posedge clk) begin
    if (op_start === 1'b1) starts <= starts + 1;
    if (suspend_req === 1'b1) suspends <= suspends + 1;
    if (soft_reset === 1'b1) resets <= resets + 1;
  end

  status_one_protect_busy_logic i_dut (
    .clk(clk), .clk_en(1'b1), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso),
    .wp_b(wp_b), .quad_command_mode(quad_command_mode), .quad_io_mode(quad_io_mode),
    .op_done(op_done), .erase_fail(erase_fail), .program_fail(program_fail), .op_start(op_start),
    .op_code(op_code), .suspend_req(suspend_req), .soft_reset(soft_reset),
    .status_one_live(status_one_live), .status_one_defaults(status_one_defaults),
    .erase_fail_flag(erase_fail_flag), .program_fail_flag(program_fail_flag)
  );

  spi_host_model i_host (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // wp_b passes a two-flop synchroniser, so give it settling cycles
  task automatic set_pins(input logic w, input logic [1:0] q);
    @(negedge clk);
    wp_b = w;
    {quad_command_mode, quad_io_mode} = q;
    repeat (4) @(negedge clk);
  endtask

  task automatic engine(input logic d, input logic e, input logic p);
    @(negedge clk);
    {op_done, erase_fail, program_fail} = {d, e, p};
    @(negedge clk);
    {op_done, erase_fail, program_fail} = 3'b000;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_reset();
    check8(status_one_live, 8'h00);
    check8(status_one_defaults, 8'h00);
  endtask

  task automatic t_latch();
    i_host.frame('{CMD_WRITE_ENABLE});
    check8(status_one_live, 8'h02);
    i_host.read_status(rd);
    check8(rd, 8'h02);
    i_host.frame('{CMD_WRITE_DISABLE});
    check8(status_one_live, 8'h00);
    i_host.frame('{CMD_PAGE_PROGRAM, 8'h00, 8'h10, 8'h00});
    i_host.frame('{CMD_REG_WRITE, 8'hFF});
    check8(8'(starts), 8'h00);
    check8(status_one_live, 8'h00);
  endtask

  task automatic t_lock();
    for (int k = 0; k < 2; k++) begin
      set_pins(1'b1, 2'b00);
      i_host.frame('{CMD_WRITE_ENABLE_VOL});
      i_host.frame('{CMD_REG_WRITE, 8'hFF});
      check8(status_one_live, 8'hFC);
      i_host.frame('{CMD_WRITE_ENABLE_VOL});
      set_pins(1'b0, 2'b00);
      i_host.frame('{CMD_REG_WRITE, 8'h00});
      check8(status_one_live, 8'hFE);
      set_pins(1'b0, k == 0 ? 2'b01 : 2'b10);
      i_host.frame('{CMD_REG_WRITE, 8'h00});
      check8(status_one_live, 8'h00);
    end
    set_pins(1'b1, 2'b00);
  endtask

  task automatic t_program();
    i_host.frame('{CMD_WRITE_ENABLE});
    i_host.frame('{CMD_PAGE_PROGRAM, 8'h00, 8'h00, 8'h00});
    check8(8'(starts), 8'h01);
    check8(op_code, CMD_PAGE_PROGRAM);
    check8(status_one_live, 8'h03);
    i_host.frame('{CMD_WRITE_DISABLE});
    check8(status_one_live, 8'h03);
    engine(1'b1, 1'b0, 1'b0);
    check8(status_one_live, 8'h00);
  endtask

  task automatic t_fail();
    for (int k = 0; k < 2; k++) begin
      i_host.frame('{CMD_WRITE_ENABLE});
      i_host.frame('{CMD_SECTOR_ERASE, 8'h00, 8'h20, 8'h00});
      i_host.frame('{CMD_SUSPEND});
      check8(8'(suspends), 8'(k + 1));
      engine(1'b1, k == 0, k == 1);
      check8({6'h00, erase_fail_flag, program_fail_flag}, k == 0 ? 8'h02 : 8'h01);
      check8(status_one_live, 8'h03);
      i_host.frame('{CMD_BLOCK_ERASE, 8'h00, 8'h00, 8'h00});
      check8(8'(starts), 8'(k + 2));
      i_host.frame('{CMD_CLEAR_STATUS});
      check8(status_one_live, 8'h00);
      check8({6'h00, erase_fail_flag, program_fail_flag}, 8'h00);
    end
  endtask

  task automatic t_defaults();
    i_host.frame('{CMD_WRITE_ENABLE});
    i_host.frame('{CMD_REG_WRITE, 8'h43});
    check8(status_one_live, 8'h43);
    check8(status_one_defaults, 8'h40);
    i_host.frame('{CMD_SUSPEND});
    check8(8'(suspends), 8'h02);
    engine(1'b1, 1'b0, 1'b0);
    i_host.read_status(rd);
    check8(rd, 8'h40);
  endtask

  task automatic t_soft_reset();
    i_host.frame('{CMD_WRITE_ENABLE_VOL});
    i_host.frame('{CMD_REG_WRITE, 8'h84});
    check8(status_one_live, 8'h84);
    i_host.frame('{CMD_RESET_ARM});
    i_host.frame('{CMD_RESET_EXECUTE});
    check8(8'(resets), 8'h01);
    check8(status_one_live, 8'h40);
  endtask

  task automatic t_addressed();
    i_host.frame('{CMD_WRITE_ENABLE});
    i_host.frame('{CMD_ADDR_REG_WRITE, 8'h80, 8'h00, 8'h00, 8'h0C});
    check8(status_one_live, 8'h0C);
    i_host.frame('{CMD_WRITE_ENABLE});
    i_host.frame('{CMD_CHIP_ERASE});
    check8(8'(starts), 8'h05);
    check8(op_code, CMD_CHIP_ERASE);
    i_host.frame('{CMD_ADDR_REG_WRITE, 8'h00, 8'h00, 8'h00, 8'hFF});
    check8(status_one_defaults, 8'h40);
    check8(status_one_live, 8'h0F);
    engine(1'b1, 1'b0, 1'b0);
    check8(status_one_live, 8'h0C);
    i_host.frame('{CMD_WRITE_ENABLE});
    i_host.frame('{CMD_ADDR_REG_WRITE, 8'h00, 8'h00, 8'h00, 8'h84});
    check8(status_one_defaults, 8'h84);
    check8(status_one_live, 8'h87);
    engine(1'b1, 1'b0, 1'b0);
    check8(status_one_live, 8'h84);
  endtask

  initial begin
    #300000;
    bad_count++;
    conclude();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_latch();
    t_lock();
    t_program();
    t_fail();
    t_defaults();
    t_soft_reset();
    t_addressed();
    conclude();
  end
endmodule
